/* File: include/als_pkg.sv */
// How it works
// R1 - Host walks every startup step strictly in order, never skipping one.
// R2 - Host waits for a stable converter clock before any configuration write.
// R3 - Host writes soft reset one, then waits at least 1 us.
// R4 - Host writes link enable zero before touching link settings.
// R5 - Host writes calibration enable zero before touching calibration settings.
// R6 - Host programs the link format field while both machines are halted.
// R7 - Host programs multiframe length as frame count minus one.
// R8 - Host selects the sync source: single-ended input or timestamp pair.
// R9 - Host writes calibration mode and offset calibration before re-enabling calibration.
// R10 - Host writes calibration enable one after the calibration settings.
// R11 - Host may set overrange enable and threshold before the link restarts.
// R12 - Host writes link enable one once all settings are in place.
// R13 - Device runs its link machine from the receiver's sync request.
// R14 - Host writes calibration trigger zero, then one; the rising edge starts it.
// R15 - Device holds a disabled machine idle and accepts setting changes meanwhile.
package als_pkg;
	// Timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int RST_WAIT_NS = 1000;
	localparam int RST_WAIT_CYC = (RST_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CS_GAP_CYC = 4;
	localparam int SCLK_HALF_CYC = 2;
	localparam int WAIT_W = 8;
	localparam int DIV_W = 2;

	// Serial frame: write flag, address, data
	localparam int FRAME_W = 24;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int BITCNT_W = 5;
	localparam logic FRAME_WRITE = 1'b0;

	// Device register map, defaults only
	localparam logic [ADDR_W-1:0] DEV_ADDR_SRST = 15'h0000;
	localparam logic [ADDR_W-1:0] DEV_ADDR_LINK_EN = 15'h0200;
	localparam logic [ADDR_W-1:0] DEV_ADDR_CAL_EN = 15'h0061;
	localparam logic [ADDR_W-1:0] DEV_ADDR_FORMAT = 15'h0201;
	localparam logic [ADDR_W-1:0] DEV_ADDR_KM1 = 15'h0202;
	localparam logic [ADDR_W-1:0] DEV_ADDR_SYNC = 15'h0203;
	localparam logic [ADDR_W-1:0] DEV_ADDR_CAL_CFG = 15'h0062;
	localparam logic [ADDR_W-1:0] DEV_ADDR_OVERRANGE_DETECT_ENABLE = 15'h0213;
	localparam logic [ADDR_W-1:0] DEV_ADDR_OVR_TH = 15'h0211;
	localparam logic [ADDR_W-1:0] DEV_ADDR_CAL_TRIG = 15'h006c;
	localparam logic [DATA_W-1:0] DEV_VAL_ONE = 8'h01;
	localparam logic [DATA_W-1:0] DEV_VAL_ZERO = 8'h00;
	localparam int DEV_CAL_BG_BIT = 0;
	localparam int DEV_CAL_OFS_BIT = 1;

	// Sequence steps
	localparam int STEP_W = 4;
	localparam logic [STEP_W-1:0] STEP_SRST = 4'h0;
	localparam logic [STEP_W-1:0] STEP_LINK_OFF = 4'h1;
	localparam logic [STEP_W-1:0] STEP_CAL_OFF = 4'h2;
	localparam logic [STEP_W-1:0] STEP_FORMAT = 4'h3;
	localparam logic [STEP_W-1:0] STEP_KM1 = 4'h4;
	localparam logic [STEP_W-1:0] STEP_SYNC = 4'h5;
	localparam logic [STEP_W-1:0] STEP_CAL_CFG = 4'h6;
	localparam logic [STEP_W-1:0] STEP_CAL_ON = 4'h7;
	localparam logic [STEP_W-1:0] STEP_OVERRANGE_DETECT_ENABLE = 4'h8;
	localparam logic [STEP_W-1:0] STEP_OVR_TH = 4'h9;
	localparam logic [STEP_W-1:0] STEP_LINK_ON = 4'ha;
	localparam logic [STEP_W-1:0] STEP_TRIG0 = 4'hb;
	localparam logic [STEP_W-1:0] STEP_TRIG1 = 4'hc;

	// Wishbone register map
	localparam int WB_ADR_W = 8;
	localparam logic [WB_ADR_W-1:0] WB_CTRL = 8'h00;
	localparam logic [WB_ADR_W-1:0] WB_STATUS = 8'h04;
	localparam logic [WB_ADR_W-1:0] WB_LINKCFG = 8'h08;
	localparam logic [WB_ADR_W-1:0] WB_CALCFG = 8'h0c;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_RECAL_BIT = 1;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_CLKOK_BIT = 2;
	localparam int ST_STEP_LSB = 8;
	localparam int LC_FMT_LSB = 0;
	localparam int LC_KM1_LSB = 8;
	localparam int LC_SYNC_BIT = 16;
	localparam int CC_BG_BIT = 0;
	localparam int CC_OFS_BIT = 1;
	localparam int CC_OVR_BIT = 2;
	localparam int CC_TH_LSB = 8;
	localparam logic [31:0] LINKCFG_RST = 32'h0000_1f00;
	localparam logic [31:0] CALCFG_RST = 32'h0000_0000;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_CLK,
		ST_SHIFT,
		ST_GAP
	} als_state_type;

	typedef struct packed {
		als_state_type st;
		logic [STEP_W-1:0] step;
		logic [FRAME_W-1:0] shreg;
		logic [BITCNT_W-1:0] bitcnt;
		logic [DIV_W-1:0] div;
		logic [WAIT_W-1:0] wait_cnt;
		logic sclk;
		logic csn;
		logic done;
		logic [31:0] linkcfg;
		logic [31:0] calcfg;
		logic ack;
		logic [31:0] dat;
	} als_regs_type;

	localparam als_regs_type REGS_RST = '{
		st: ST_IDLE,
		step: STEP_SRST,
		shreg: '0,
		bitcnt: '0,
		div: '0,
		wait_cnt: '0,
		sclk: 1'b0,
		csn: 1'b1,
		done: 1'b0,
		linkcfg: LINKCFG_RST,
		calcfg: CALCFG_RST,
		ack: 1'b0,
		dat: '0
	};
endpackage

/* File: design/als_startup_host.sv */
`timescale 1ns/1ps
module als_startup_host
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [als_pkg::WB_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic dev_clk_ok_i,
	output logic spi_sclk_o,
	output logic spi_csn_o,
	output logic spi_sdi_o
);
	import als_pkg::*;

	als_regs_type r;
	als_regs_type n;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Address and data of each step, in the fixed order of the sequence
	function automatic logic [FRAME_W-1:0] frame_of(input logic [STEP_W-1:0] step,
		input logic [31:0] lc, input logic [31:0] cc);
		logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] d;
		a = DEV_ADDR_SRST;
		d = DEV_VAL_ZERO;
		case (step)
			STEP_SRST:
			begin
				a = DEV_ADDR_SRST;
				d = DEV_VAL_ONE; // R3
			end
			STEP_LINK_OFF:
			begin
				a = DEV_ADDR_LINK_EN;
				d = DEV_VAL_ZERO; // R4
			end
			STEP_CAL_OFF:
			begin
				a = DEV_ADDR_CAL_EN;
				d = DEV_VAL_ZERO; // R5
			end
			STEP_FORMAT:
			begin
				a = DEV_ADDR_FORMAT;
				d = lc[LC_FMT_LSB +: DATA_W]; // R6
			end
			STEP_KM1:
			begin
				a = DEV_ADDR_KM1;
				d = lc[LC_KM1_LSB +: DATA_W]; // R7
			end
			STEP_SYNC:
			begin
				a = DEV_ADDR_SYNC;
				d = DEV_VAL_ZERO;
				d[0] = lc[LC_SYNC_BIT]; // R8
			end
			STEP_CAL_CFG:
			begin
				a = DEV_ADDR_CAL_CFG;
				d = DEV_VAL_ZERO;
				d[DEV_CAL_BG_BIT] = cc[CC_BG_BIT]; // R9
				d[DEV_CAL_OFS_BIT] = cc[CC_OFS_BIT]; // R9
			end
			STEP_CAL_ON:
			begin
				a = DEV_ADDR_CAL_EN;
				d = DEV_VAL_ONE; // R10
			end
			STEP_OVERRANGE_DETECT_ENABLE:
			begin
				a = DEV_ADDR_OVERRANGE_DETECT_ENABLE;
				d = DEV_VAL_ZERO;
				d[0] = cc[CC_OVR_BIT]; // R11
			end
			STEP_OVR_TH:
			begin
				a = DEV_ADDR_OVR_TH;
				d = cc[CC_TH_LSB +: DATA_W]; // R11
			end
			STEP_LINK_ON:
			begin
				a = DEV_ADDR_LINK_EN;
				d = DEV_VAL_ONE; // R12
			end
			STEP_TRIG0:
			begin
				a = DEV_ADDR_CAL_TRIG;
				d = DEV_VAL_ZERO; // R14
			end
			STEP_TRIG1:
			begin
				a = DEV_ADDR_CAL_TRIG;
				d = DEV_VAL_ONE; // R14
			end
			default:
			begin
				a = DEV_ADDR_SRST;
				d = DEV_VAL_ZERO;
			end
		endcase
		return {FRAME_WRITE, a, d};
	endfunction

	always_comb
	begin
		logic busy;
		logic wr_go;
		logic [31:0] rd;
		busy = 1'b0;
		wr_go = 1'b0;
		rd = '0;
		n = r;
		busy = (r.st != ST_IDLE);

		// Wishbone slave: ack one cycle after the request, then drop it
		n.ack = wb_cyc_i && wb_stb_i && !r.ack;
		wr_go = wb_cyc_i && wb_stb_i && r.ack && wb_we_i;
		if (wb_adr_i == WB_STATUS)
		begin
			rd[ST_BUSY_BIT] = busy;
			rd[ST_DONE_BIT] = r.done;
			rd[ST_CLKOK_BIT] = dev_clk_ok_i;
			rd[ST_STEP_LSB +: STEP_W] = r.step;
		end
		else if (wb_adr_i == WB_LINKCFG)
		begin
			rd = r.linkcfg;
		end
		else if (wb_adr_i == WB_CALCFG)
		begin
			rd = r.calcfg;
		end
		else
		begin
			rd = '0;
		end
		if (n.ack)
		begin
			n.dat = rd;
		end

		// Settings are frozen while a sequence runs
		if (wr_go && !busy)
		begin
			if (wb_adr_i == WB_LINKCFG)
			begin
				n.linkcfg = merge(r.linkcfg, wb_dat_i, wb_sel_i);
			end
			else if (wb_adr_i == WB_CALCFG)
			begin
				n.calcfg = merge(r.calcfg, wb_dat_i, wb_sel_i);
			end
			else if (wb_adr_i == WB_CTRL && wb_sel_i[0])
			begin
				if (wb_dat_i[CTRL_START_BIT])
				begin
					n.done = 1'b0;
					n.step = STEP_SRST;
					n.st = ST_WAIT_CLK; // R1
				end
				else if (wb_dat_i[CTRL_RECAL_BIT])
				begin
					n.done = 1'b0;
					n.step = STEP_TRIG0;
					n.st = ST_WAIT_CLK; // R14
				end
			end
		end

		// Serial sequencer
		case (r.st)
			ST_IDLE:
			begin
				n.csn = 1'b1;
				n.sclk = 1'b0;
			end
			ST_WAIT_CLK:
			begin
				if (dev_clk_ok_i) // R2
				begin
					n.shreg = frame_of(r.step, r.linkcfg, r.calcfg);
					n.bitcnt = BITCNT_W'(FRAME_W);
					n.div = '0;
					n.sclk = 1'b0;
					n.csn = 1'b0;
					n.st = ST_SHIFT;
				end
			end
			ST_SHIFT:
			begin
				if (r.div == DIV_W'(SCLK_HALF_CYC - 1))
				begin
					n.div = '0;
					if (!r.sclk)
					begin
						n.sclk = 1'b1;
					end
					else
					begin
						n.sclk = 1'b0;
						n.shreg = {r.shreg[FRAME_W-2:0], 1'b0};
						n.bitcnt = r.bitcnt - BITCNT_W'(1);
						if (r.bitcnt == BITCNT_W'(1))
						begin
							n.csn = 1'b1;
							n.st = ST_GAP;
							if (r.step == STEP_SRST)
							begin
								n.wait_cnt = WAIT_W'(RST_WAIT_CYC); // R3
							end
							else
							begin
								n.wait_cnt = WAIT_W'(CS_GAP_CYC);
							end
						end
					end
				end
				else
				begin
					n.div = r.div + DIV_W'(1);
				end
			end
			ST_GAP:
			begin
				if (r.wait_cnt > WAIT_W'(1))
				begin
					n.wait_cnt = r.wait_cnt - WAIT_W'(1);
				end
				else if (r.step == STEP_TRIG1)
				begin
					n.done = 1'b1;
					n.st = ST_IDLE;
				end
				else
				begin
					n.step = r.step + STEP_W'(1); // R1
					n.st = ST_WAIT_CLK;
				end
			end
			default:
			begin
				n.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			r <= REGS_RST;
		end
		else
		begin
			r <= n;
		end
	end

	assign wb_ack_o = r.ack;
	assign wb_dat_o = r.dat;
	assign spi_sclk_o = r.sclk;
	assign spi_csn_o = r.csn;
	assign spi_sdi_o = r.csn ? 1'b0 : r.shreg[FRAME_W-1];
endmodule

/* File: tb/als_startup_host_assertions.sv */
`timescale 1ns/1ps
module als_startup_host_assertions
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [als_pkg::WB_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic dev_clk_ok_i,
	input wire logic spi_sclk_o,
	input wire logic spi_csn_o,
	input wire logic spi_sdi_o
);
	import als_pkg::*;
	logic [5:0] rises;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	always_ff @(posedge clk_i)
	begin
		if (rst_i || spi_csn_o)
			rises <= 6'h00;
		else if ($rose(spi_sclk_o))
			rises <= rises + 6'h01;
	end
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_idle_lines: assert property (spi_csn_o |-> !spi_sclk_o && !spi_sdi_o)
		else $error("idle lines");
	a_sclk_high: assert property ($rose(spi_sclk_o) |=> spi_sclk_o ##1 !spi_sclk_o)
		else $error("sclk high time");
	a_sdi_hold: assert property (spi_sclk_o |-> $stable(spi_sdi_o))
		else $error("sdi moved");
	a_clk_stall: assert property (spi_csn_o && !dev_clk_ok_i |=> spi_csn_o)
		else $error("frame without clock");
	a_cs_gap: assert property ($rose(spi_csn_o) |-> spi_csn_o [*4])
		else $error("gap short");
	a_frame_bits: assert property ($rose(spi_csn_o) |-> rises == 6'h18)
		else $error("frame length");
	cover property ($fell(spi_csn_o));
	cover property (wb_ack_o && wb_we_i);
	cover property (!dev_clk_ok_i && spi_csn_o);
endmodule

/* File: tb/als_dev_model.sv */
`timescale 1ns/1ps
module als_dev_model
(
	input wire logic clk_i,
	input wire logic sclk_i,
	input wire logic csn_i,
	input wire logic sdi_i
);
	import als_pkg::*;
	logic [23:0] sh;
	logic [23:0] frames[$];
	logic [7:0] regs[logic [14:0]];
	int gaps[$];
	int gap = 0;
	int bits = 0;
	int cal_runs = 0;
	int link_starts = 0;
	always @(posedge sclk_i)
		if (csn_i === 1'b0)
		begin
			sh = {sh[22:0], sdi_i};
			bits++;
		end
	always @(posedge csn_i)
		if (bits != 0)
		begin
			frames.push_back(sh);
			bits = 0;
			if (sh[22:8] == DEV_ADDR_SRST && sh[0])
				regs.delete();
			// Link machine restarts when its enable is written from zero to one
			if (sh[22:8] == DEV_ADDR_LINK_EN && sh[0] && regs.exists(DEV_ADDR_LINK_EN))
				if (!regs[DEV_ADDR_LINK_EN][0])
					link_starts++;
			// Trigger edge starts calibration only while enabled
			if (sh[22:8] == DEV_ADDR_CAL_TRIG && sh[0] && regs.exists(DEV_ADDR_CAL_TRIG)
				&& regs.exists(DEV_ADDR_CAL_EN))
				if (!regs[DEV_ADDR_CAL_TRIG][0] && regs[DEV_ADDR_CAL_EN][0])
					cal_runs++;
			regs[sh[22:8]] = sh[7:0];
		end
	always @(posedge clk_i)
		if (csn_i === 1'b1)
			gap++;
		else if (gap != 0)
		begin
			gaps.push_back(gap);
			gap = 0;
		end
endmodule

/* File: tb/als_startup_host_test.sv */
`timescale 1ns/1ps
module als_startup_host_test;
	import als_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o, rd, lc, cc;
	logic wb_ack_o, spi_sclk_o, spi_csn_o, spi_sdi_o;
	logic dev_clk_ok_i = 1'b0;
	logic [31:0] seed = 32'h86b1;
	int n_fail = 0;
	int num_checks = 0;
	int cycles = 0;
	int base, gbase, runs, lstarts;
	always #2.5 clk_i = ~clk_i;
	als_startup_host DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .dev_clk_ok_i, .spi_sclk_o, .spi_csn_o, .spi_sdi_o);
	als_dev_model model (.clk_i, .sclk_i(spi_sclk_o), .csn_i(spi_csn_o), .sdi_i(spi_sdi_o));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [23:0] exp_frame(input int i, input logic [31:0] l, c);
		logic [14:0] a[13];
		logic [7:0] d[13];
		a = '{DEV_ADDR_SRST, DEV_ADDR_LINK_EN, DEV_ADDR_CAL_EN, DEV_ADDR_FORMAT, DEV_ADDR_KM1,
			DEV_ADDR_SYNC, DEV_ADDR_CAL_CFG, DEV_ADDR_CAL_EN, DEV_ADDR_OVERRANGE_DETECT_ENABLE, DEV_ADDR_OVR_TH,
			DEV_ADDR_LINK_EN, DEV_ADDR_CAL_TRIG, DEV_ADDR_CAL_TRIG};
		d = '{DEV_VAL_ONE, DEV_VAL_ZERO, DEV_VAL_ZERO, l[7:0], l[15:8], {7'h0, l[16]},
			{6'h0, c[1:0]}, DEV_VAL_ONE, {7'h0, c[2]}, c[15:8],
			DEV_VAL_ONE, DEV_VAL_ZERO, DEV_VAL_ONE};
		return {FRAME_WRITE, a[i], d[i]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do
			@(posedge clk_i);
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			n_fail++;
			finish_test();
		end
	end
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, WB_LINKCFG, 32'h0);
		check(rd, LINKCFG_RST);
		wb(1'b0, WB_STATUS, 32'h0);
		check(rd, 32'h0);
		wb(1'b1, 8'h10, 32'hffff_ffff);
		wb(1'b0, 8'h10, 32'h0);
		check(rd, 32'h0);
		for (int k = 0; k < 3; k++)
		begin
			seed = xs(seed);
			lc = (k == 2) ? 32'h0001_ffff : seed & 32'h0001_ffff;
			seed = xs(seed);
			cc = (k == 2) ? 32'h0000_ff07 : seed & 32'h0000_ff07;
			wb(1'b1, WB_LINKCFG, lc);
			wb(1'b1, WB_CALCFG, cc);
			wb(1'b0, WB_CALCFG, 32'h0);
			check(rd, cc);
			base = model.frames.size();
			gbase = model.gaps.size();
			runs = model.cal_runs;
			lstarts = model.link_starts;
			dev_clk_ok_i <= 1'b0;
			wb(1'b1, WB_CTRL, 32'h1);
			wb(1'b1, WB_LINKCFG, ~lc);
			repeat (40) @(posedge clk_i);
			check(model.frames.size(), base);
			dev_clk_ok_i <= 1'b1;
			do
				wb(1'b0, WB_STATUS, 32'h0);
			while (rd[ST_DONE_BIT] !== 1'b1);
			check({29'h0, rd[2:0]}, 32'h6);
			wb(1'b0, WB_LINKCFG, 32'h0);
			check(rd, lc);
			wb(1'b1, WB_CTRL, 32'h2);
			while (model.frames.size() < base + 15)
				@(posedge clk_i);
			do
				wb(1'b0, WB_STATUS, 32'h0);
			while (rd[ST_BUSY_BIT] !== 1'b0);
			for (int i = 0; i < 15; i++)
				check({8'h0, model.frames[base + i]}, {8'h0, exp_frame(i % 13 + i / 13 * 11, lc, cc)});
			check(model.frames.size(), base + 15);
			check(model.gaps[gbase + 1] >= RST_WAIT_CYC, 32'h1);
			check(model.cal_runs - runs, 32'h2);
			check(model.link_starts - lstarts, 32'h1);
		end
		finish_test();
	end
endmodule
bind als_startup_host als_startup_host_assertions chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .dev_clk_ok_i, .spi_sclk_o,
	.spi_csn_o, .spi_sdi_o);
